// [hdl/pors_filt_if.sv]
// Purpose: Carries one raw level and its filtered copy.
// Assumes: Single clock domain.
// Notes:   One instance per filtered signal.
`timescale 1ns/1ps
`default_nettype none
interface pors_filt_if;
  logic raw;
  logic filt;
  modport filter (input raw, output filt);
  modport user   (output raw, input filt);
endinterface : pors_filt_if
`default_nettype wire

// [hdl/pors_filter.sv]
// Purpose: Glitch filter; output follows input once stable for LEN cycles.
// Assumes: Input synchronous to clk_in.
// Notes:   Output resets low, which asserts reset.
`timescale 1ns/1ps
`default_nettype none
module pors_filter #(
  parameter int unsigned LEN = 4
) (
  // Clock and reset
  input  wire logic      clk_in,
  input  wire logic      reset_n_in,
  // Filtered signal
  pors_filt_if.filter    sig
);
  logic [4:0] cnt_q, cnt_d;
  logic       filt_q, filt_d;

  always_comb begin
    cnt_d  = 5'h00;
    filt_d = filt_q;
    if (sig.raw != filt_q) begin
      if (cnt_q == 5'(LEN - 1)) begin
        filt_d = sig.raw;
      end else begin
        cnt_d = cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q  <= 5'h00;
      filt_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      filt_q <= filt_d;
    end
  end

  assign sig.filt = filt_q;
endmodule : pors_filter
`default_nettype wire

// [hdl/pors_pkg.sv]
// Purpose: Constants for the power-on reset sequencer.
// Assumes: A 10 MHz clock, used as the oscillator clock.
// Notes:   Times are in ns; filter cycle counts are derived from them.
package pors_pkg;

  localparam int unsigned CLK_PERIOD_NS       = 100;
  localparam int unsigned OSC_CHECK_CYCLES    = 1032;
  localparam int unsigned FUSE_LOAD_CYCLES    = 1160;
  localparam int unsigned PUMP_UP_CYCLES      = 688;
  localparam int unsigned BANK_UP_CYCLES      = 617;
  localparam int unsigned WARM_HOLD_CYCLES    = 2256;
  localparam int unsigned POR_FILTER_MIN_NS   = 475;
  localparam int unsigned POR_FILTER_MAX_NS   = 2000;
  localparam int unsigned SUPPLY_GLITCH_MIN_NS = 250;
  localparam int unsigned SUPPLY_GLITCH_MAX_NS = 1000;
  // Least filter time rounds up, longest rounds down; the filter count lies between.
  localparam int unsigned POR_FILTER_MIN_CYC  = (POR_FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned POR_FILTER_MAX_CYC  = POR_FILTER_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned SUP_FILTER_MIN_CYC  = (SUPPLY_GLITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SUP_FILTER_MAX_CYC  = SUPPLY_GLITCH_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned POR_FILTER_CYC      = POR_FILTER_MIN_CYC;
  localparam int unsigned SUP_FILTER_CYC      = SUP_FILTER_MAX_CYC;
  localparam int unsigned CNT_W               = 12;
  localparam logic [31:0] BOOT_ADDRESS        = 32'h0000_0000;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_OSC   = 6'h02,
    ST_FUSE  = 6'h04,
    ST_PUMP  = 6'h08,
    ST_BANK  = 6'h10,
    ST_RUN   = 6'h20
  } pors_state_t;

endpackage : pors_pkg

// [hdl/pors_sequencer.sv]
// Purpose: Power-on reset and power-up sequencing.
// Assumes: clk_in is the oscillator clock at 10 MHz; inputs synchronous.
// Notes:   Analog thresholds and pin timing are outside this block.
//
// Summary of operation
// - After reset release run oscillator check 1032 cycles, then fuse load 1160.
// - Then flash pump power-up 688 cycles, then flash bank 617, in order.
// - After the last phase release CPU reset; boot fetch address is zero.
// - Isolate core and I/O controls while either power-good is low.
// - Low I/O supply asserts the internal power-on reset.
// - Core supply out of range tristates all outputs asynchronously and asserts reset.
// - Low power mode disables the supply monitor and its reset generation.
// - External reset filtered: under 475 ns ignored, over 2000 ns resets.
// - Supply indication glitches under 250 ns are suppressed; those of 1000 ns or longer pass.
// - Warm reset stays low at least 2256 cycles after reset input releases.
`timescale 1ns/1ps
`default_nettype none
module pors_sequencer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // Supply monitor and external reset
  input  wire logic        core_power_good_in,
  input  wire logic        io_power_good_in,
  input  wire logic        power_on_reset_n_in,
  input  wire logic        low_power_mode_in,
  // Control outputs
  output logic             isolate_out,
  output logic             outputs_hiz_out,
  output logic             por_active_out,
  output logic             cpu_reset_n_out,
  output logic [31:0]      boot_address_out,
  output logic [5:0]       phase_out,
  // Warm reset pin, open drain
  input  wire logic        warm_reset_n_in,
  output logic             warm_reset_n_out,
  output logic             warm_reset_n_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filters.

  pors_filt_if por_f ();
  pors_filt_if core_f ();
  pors_filt_if io_f ();

  assign por_f.raw  = power_on_reset_n_in;
  assign core_f.raw = core_power_good_in;
  assign io_f.raw   = io_power_good_in;

  pors_filter #(.LEN(pors_pkg::POR_FILTER_CYC)) u_por_filt (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .sig        (por_f.filter)
  );

  pors_filter #(.LEN(pors_pkg::SUP_FILTER_CYC)) u_core_filt (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .sig        (core_f.filter)
  );

  pors_filter #(.LEN(pors_pkg::SUP_FILTER_CYC)) u_io_filt (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .sig        (io_f.filter)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Reset sources.

  logic monitor_on;
  logic core_bad;
  logic io_bad;
  logic por_req;

  assign monitor_on = !low_power_mode_in;
  assign core_bad   = monitor_on && !core_f.filt;
  assign io_bad     = monitor_on && !io_f.filt;
  assign por_req    = !por_f.filt || io_bad || core_bad;

  // Raw core-good drop tristates without waiting for the clock.
  assign outputs_hiz_out = (monitor_on && !core_power_good_in) || core_bad;
  assign isolate_out     = !core_f.filt || !io_f.filt;
  assign por_active_out  = por_req;

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer.

  pors_pkg::pors_state_t       state_q, state_d;
  logic [pors_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  logic [pors_pkg::CNT_W-1:0]  warm_q, warm_d;
  logic                        cpu_rel_q, cpu_rel_d;
  logic                        osc_done;
  logic                        fuse_done;
  logic                        pump_done;
  logic                        bank_done;

  function automatic logic [pors_pkg::CNT_W-1:0] last_of(input int unsigned n);
    last_of = pors_pkg::CNT_W'(n - 1);
  endfunction : last_of

  assign osc_done  = cnt_q == last_of(pors_pkg::OSC_CHECK_CYCLES);
  assign fuse_done = cnt_q == last_of(pors_pkg::FUSE_LOAD_CYCLES);
  assign pump_done = cnt_q == last_of(pors_pkg::PUMP_UP_CYCLES);
  assign bank_done = cnt_q == last_of(pors_pkg::BANK_UP_CYCLES);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q + 12'h001;
    case (state_q)
      pors_pkg::ST_RESET: begin
        cnt_d = 12'h000;
        if (!por_req) begin
          state_d = pors_pkg::ST_OSC;
        end
      end
      pors_pkg::ST_OSC: begin
        if (osc_done) begin
          state_d = pors_pkg::ST_FUSE;
          cnt_d   = 12'h000;
        end
      end
      pors_pkg::ST_FUSE: begin
        if (fuse_done) begin
          state_d = pors_pkg::ST_PUMP;
          cnt_d   = 12'h000;
        end
      end
      pors_pkg::ST_PUMP: begin
        if (pump_done) begin
          state_d = pors_pkg::ST_BANK;
          cnt_d   = 12'h000;
        end
      end
      pors_pkg::ST_BANK: begin
        if (bank_done) begin
          state_d = pors_pkg::ST_RUN;
          cnt_d   = 12'h000;
        end
      end
      pors_pkg::ST_RUN: begin
        cnt_d = 12'h000;
      end
      default: begin
        state_d = pors_pkg::ST_RESET;
        cnt_d   = 12'h000;
      end
    endcase
    if (por_req) begin
      state_d = pors_pkg::ST_RESET;
      cnt_d   = 12'h000;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= pors_pkg::ST_RESET;
      cnt_q   <= 12'h000;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU release.

  always_comb begin
    cpu_rel_d = 1'b0;
    if (state_d == pors_pkg::ST_RUN) begin
      cpu_rel_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cpu_rel_q <= 1'b0;
    end else begin
      cpu_rel_q <= cpu_rel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Warm reset hold.

  // Warm reset hold counter restarts on every reset request.
  always_comb begin
    warm_d = warm_q;
    if (por_req) begin
      warm_d = 12'h000;
    end else if (warm_q != pors_pkg::CNT_W'(pors_pkg::WARM_HOLD_CYCLES)) begin
      warm_d = warm_q + 12'h001;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      warm_q <= 12'h000;
    end else begin
      warm_q <= warm_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  logic warm_low;

  // Sequence end comes after the 2256 hold, so CPU release also covers it.
  assign warm_low            = !cpu_rel_q || warm_q != pors_pkg::CNT_W'(pors_pkg::WARM_HOLD_CYCLES);
  assign warm_reset_n_out    = 1'b0;
  assign warm_reset_n_oe_out = warm_low;
  assign cpu_reset_n_out     = cpu_rel_q && warm_reset_n_in;
  assign boot_address_out    = pors_pkg::BOOT_ADDRESS;
  assign phase_out           = state_q;

endmodule : pors_sequencer
`default_nettype wire

// [test/pors_monitor.sv]
// Purpose: Port checker for the sequencer.
// Assumes: One clock, reset asynchronous and active low.
// Notes:   Bound to pors_sequencer below.
`timescale 1ns/1ps
`default_nettype none
module pors_monitor (
  // Watched ports
  input wire logic        clk_in, reset_n_in, core_power_good_in, io_power_good_in,
  input wire logic        power_on_reset_n_in, low_power_mode_in, isolate_out, outputs_hiz_out,
  input wire logic        por_active_out, cpu_reset_n_out, warm_reset_n_oe_out,
  input wire logic [31:0] boot_address_out,
  input wire logic [5:0]  phase_out
);
  logic [5:0]  prev_q;
  logic [11:0] cnt_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Counts how long the phase has held its value.
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prev_q <= 6'h01;
      cnt_q  <= 12'h000;
    end else begin
      prev_q <= phase_out;
      cnt_q  <= (phase_out == prev_q) ? cnt_q + 12'h001 : 12'h001;
    end
  end
  ////////////////////////////////////////
  phase_len_a: assert property (prev_q != phase_out && prev_q != 6'h01 && phase_out != 6'h01 |->
    cnt_q == ((prev_q == 6'h02) ? 12'h408 : (prev_q == 6'h04) ? 12'h488 : (prev_q == 6'h08) ? 12'h2b0 : 12'h269))
    else $error("phase length wrong");
  phase_order_a: assert property ($changed(phase_out) |-> phase_out == 6'h01 || phase_out == {$past(phase_out[4:0]), 1'b0})
    else $error("phase order wrong");
  cpu_release_a: assert property ($rose(phase_out == 6'h20) |-> ##[0:1] cpu_reset_n_out)
    else $error("cpu reset not released");
  boot_addr_a: assert property (boot_address_out == 32'h0000_0000)
    else $error("boot address wrong");
  io_low_reset_a: assert property ((!io_power_good_in && !low_power_mode_in) [*8] ##1 (!io_power_good_in) [*4]
    |-> ##[0:2] (isolate_out && por_active_out)) else $error("io supply low not handled");
  core_hiz_a: assert property (!core_power_good_in && !low_power_mode_in |-> outputs_hiz_out)
    else $error("outputs not tristated");
  low_power_a: assert property (low_power_mode_in |-> !outputs_hiz_out)
    else $error("monitor active in low power");
  por_abort_a: assert property (!power_on_reset_n_in [*6] |-> ##[0:2] phase_out == 6'h01)
    else $error("reset did not abort");
  warm_hold_a: assert property (phase_out == 6'h02 || (phase_out == 6'h04 && cnt_q < 12'h4c8) |-> warm_reset_n_oe_out)
    else $error("warm reset released early");
endmodule : pors_monitor
bind pors_sequencer pors_monitor mon (.clk_in, .reset_n_in, .core_power_good_in, .io_power_good_in,
  .power_on_reset_n_in, .low_power_mode_in, .isolate_out, .outputs_hiz_out, .por_active_out,
  .cpu_reset_n_out, .warm_reset_n_oe_out, .boot_address_out, .phase_out);
`default_nettype wire

// [test/pors_supervisor.sv]
// Purpose: External supervisor model driving the power-on reset pin.
// Assumes: Bench commands change just after a rising edge.
// Notes:   Warm reset pin is pulled up while nobody drives it.
`timescale 1ns/1ps
`default_nettype none
module pors_supervisor (
  // Clock and commands
  input  wire logic clk_in,
  input  wire logic supply_bad_in,
  input  wire logic pulse_in,
  // Pins
  input  wire logic warm_oe_in,
  output logic      por_n_out,
  output logic      warm_pin_out
);
  initial por_n_out = 1'b0;
  always @(posedge clk_in) por_n_out <= !(supply_bad_in || pulse_in);
  assign warm_pin_out = !warm_oe_in;
endmodule : pors_supervisor
`default_nettype wire

// [test/power_on_reset_sequencer_tb.sv]
// Purpose: Self-checking bench for the power-on reset sequencer.
// Assumes: 10 MHz clock; the supervisor model drives the reset pin.
// Notes:   Phase lengths are compared with a queue of expected counts.
`timescale 1ns/1ps
`default_nettype none
module power_on_reset_sequencer_tb;
  logic        clk_in = 1'b0, reset_n_in = 1'b0, core_power_good_in = 1'b1, io_power_good_in = 1'b1;
  logic        low_power_mode_in = 1'b0, supply_bad = 1'b1, pulse = 1'b0, power_on_reset_n_in, warm_reset_n_in;
  logic        isolate_out, outputs_hiz_out, por_active_out, cpu_reset_n_out, warm_reset_n_oe_out, warm_reset_n_out;
  logic [31:0] boot_address_out;
  logic [5:0]  phase_out;
  int          fail_count = 0, samples_checked = 0, cycles = 0;
  int          dur[$] = {1032, 1160, 688, 617};
  always #50 clk_in = ~clk_in;
  pors_sequencer dut (.clk_in, .reset_n_in, .core_power_good_in, .io_power_good_in, .power_on_reset_n_in,
    .low_power_mode_in, .isolate_out, .outputs_hiz_out, .por_active_out, .cpu_reset_n_out, .boot_address_out,
    .phase_out, .warm_reset_n_in, .warm_reset_n_out, .warm_reset_n_oe_out);
  pors_supervisor sup (.clk_in, .supply_bad_in(supply_bad), .pulse_in(pulse), .warm_oe_in(warm_reset_n_oe_out),
    .por_n_out(power_on_reset_n_in), .warm_pin_out(warm_reset_n_in));
  ////////////////////////////////////////
  task automatic chk_sig(logic [31:0] got, logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_sig
  task automatic chk_len(int got, int exp);
    samples_checked++;
    if (got != exp) begin
      fail_count++;
      $display("MISMATCH at %0t: length %0d expected %0d", $time, got, exp);
    end
  endtask : chk_len
  task automatic wait_ph(logic [5:0] p);
    int k;
    k = 0;
    while (phase_out !== p && k < 9000) begin
      @(negedge clk_in);
      k++;
    end
    if (phase_out !== p) begin
      fail_count++;
      $display("MISMATCH at %0t: phase %h not reached", $time, p);
    end
  endtask : wait_ph
  task automatic measure();
    logic [5:0] p;
    int n;
    for (int i = 0; i < 4; i++) begin
      p = phase_out;
      n = 0;
      while (phase_out === p) begin
        @(negedge clk_in);
        n++;
      end
      chk_len(n, dur[i]);
    end
  endtask : measure
  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH at %0t: run did not finish", $time);
      final_report();
    end
  end
  initial begin
    void'($urandom(1882));
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    supply_bad <= 1'b0;
    wait_ph(6'h02);
    fork
      measure();
      begin
        repeat (1500) @(posedge clk_in);
        pulse <= 1'b1;
        repeat ($urandom % 4 + 1) @(posedge clk_in);
        pulse <= 1'b0;
      end
    join
    @(negedge clk_in);
    chk_sig(32'(cpu_reset_n_out), 32'h1);
    chk_sig(boot_address_out, 32'h0);
    chk_sig(32'(isolate_out), 32'h0);
    chk_sig(32'(warm_reset_n_oe_out), 32'h0);
    $display("test 1 done");
    @(posedge clk_in);
    io_power_good_in <= 1'b0;
    supply_bad <= 1'b1;
    repeat (25) @(posedge clk_in);
    @(negedge clk_in);
    chk_sig(32'(isolate_out), 32'h1);
    chk_sig(32'(por_active_out), 32'h1);
    chk_sig(32'(warm_reset_n_oe_out), 32'h1);
    chk_sig(32'(warm_reset_n_out), 32'h0);
    @(posedge clk_in);
    io_power_good_in <= 1'b1;
    supply_bad <= 1'b0;
    wait_ph(6'h08);
    @(posedge clk_in);
    supply_bad <= 1'b1;
    repeat (25) @(posedge clk_in);
    @(negedge clk_in);
    chk_sig(32'(phase_out), 32'h1);
    @(posedge clk_in);
    supply_bad <= 1'b0;
    wait_ph(6'h02);
    measure();
    $display("test 2 done");
    @(posedge clk_in);
    io_power_good_in <= 1'b0;
    repeat ($urandom % 8 + 1) @(posedge clk_in);
    io_power_good_in <= 1'b1;
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    chk_sig(32'(isolate_out), 32'h0);
    chk_sig(32'(phase_out), 32'h20);
    @(posedge clk_in);
    low_power_mode_in <= 1'b1;
    core_power_good_in <= 1'b0;
    repeat (15) @(posedge clk_in);
    @(negedge clk_in);
    chk_sig(32'(outputs_hiz_out), 32'h0);
    chk_sig(32'(por_active_out), 32'h0);
    chk_sig(32'(phase_out), 32'h20);
    @(posedge clk_in);
    low_power_mode_in <= 1'b0;
    #1;
    chk_sig(32'(outputs_hiz_out), 32'h1);
    chk_sig(32'(por_active_out), 32'h1);
    $display("test 3 done");
    final_report();
  end
endmodule : power_on_reset_sequencer_tb
`default_nettype wire
